// ---- logic/ocpc_top.v ----
`timescale 1ns/100ps
// Overview of operation
// [RQ1] Bits 5:4 select main 0, internal 1 (reset), internal/4 2 or 30 kHz 3.
// [RQ2] Bit 1 stops the internal oscillator when 1 and resets to 0.
// [RQ3] Bit 0 stops the main oscillator when 1, which is its reset value.
// [RQ4] Config bits 3:2 read zero and software preserves them on rewrite.
// [RQ5] The translation loads at reset and reloads on a new crystal code.
// [RQ6] PLL output is oscillator times multiplier over divider plus one.
// [RQ7] Translation bits 13:5 hold the read-only PLL multiplier.
// [RQ8] Translation bits 4:0 hold the read-only PLL input divider.
// [RQ9] Translation bits 31:14 read zero and writes to it do nothing.
// [RQ10] Config bits 9:6 hold the crystal code, reset 0xb for 6 MHz.
// [RQ11] With use-extended set, source, bypass and power-down follow it.
// [RQ12] Rewriting the same crystal code leaves multiplier and divider alone.
`include "ocpc_map.vh"

module ocpc_top (
  input  wire        core_clk_in,
  input  wire        reset_n_in,
  input  wire        hsel_in,
  input  wire [31:0] haddr_in,
  input  wire [1:0]  htrans_in,
  input  wire        hwrite_in,
  input  wire [2:0]  hsize_in,
  input  wire [31:0] hwdata_in,
  input  wire        hready_in,
  output wire        hreadyout_out,
  output wire        hresp_out,
  output wire [31:0] hrdata_out,
  output wire [2:0]  osc_source_out,
  output wire        internal_osc_run_out,
  output wire        main_osc_run_out,
  output wire        pll_bypass_out,
  output wire        pll_power_down_out,
  output wire [8:0]  pll_mult_out,
  output wire [4:0]  pll_div_out
);

  // ------------------------------------------------------------
  // Crystal code to PLL settings
  // ------------------------------------------------------------
  // Divider is the crystal rounded to whole MHz minus one
  function [4:0] ocpc_div_of;
    input [3:0] code;
    begin
      case (code)
        4'h0:    ocpc_div_of = 5'h00;
        4'h1:    ocpc_div_of = 5'h01;
        4'h2:    ocpc_div_of = 5'h01;
        4'h3:    ocpc_div_of = 5'h01;
        4'h4:    ocpc_div_of = 5'h03;
        4'h5:    ocpc_div_of = 5'h03;
        4'h6:    ocpc_div_of = 5'h03;
        4'h7:    ocpc_div_of = 5'h03;
        4'h8:    ocpc_div_of = 5'h04;
        4'h9:    ocpc_div_of = 5'h04;
        4'ha:    ocpc_div_of = 5'h04;
        4'hb:    ocpc_div_of = 5'h05;
        4'hc:    ocpc_div_of = 5'h05;
        4'hd:    ocpc_div_of = 5'h06;
        4'he:    ocpc_div_of = 5'h07;
        default: ocpc_div_of = 5'h07;
      endcase
    end
  endfunction

  // Word address match on the decoded low bits
  function ocpc_hit;
    input [11:0] addr;
    input [11:0] base;
    begin
      ocpc_hit = (addr == base);
    end
  endfunction

  // ------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------
  reg        hready_q;
  reg        rd_pend_q;
  reg        wr_pend_q;
  reg [11:0] addr_q;
  reg [31:0] hrdata_q;
  reg [1:0]  src_q;
  reg [3:0]  crystal_value_code_q;
  reg        internal_oscillator_off_q;
  reg        main_oscillator_off_q;
  reg        bypass_q;
  reg        pwrdn_q;
  reg        ext_use_q;
  reg [2:0]  ext_src_q;
  reg        ext_bypass_q;
  reg        ext_pwrdn_q;
  reg [8:0]  mult_q;
  reg [4:0]  div_q;
  reg [2:0]  osc_src_q;
  reg        internal_oscillator_run_q;
  reg        main_oscillator_run_q;
  reg        pll_bypass_q;
  reg        pll_pwrdn_q;
  reg        hresp_q;
  reg [31:0] rd_word_d;
  reg [1:0]  src_d;
  reg [3:0]  crystal_value_code_d;
  reg        internal_oscillator_off_d;
  reg        main_oscillator_off_d;
  reg        bypass_d;
  reg        pwrdn_d;
  reg        ext_use_d;
  reg [2:0]  ext_src_d;
  reg        ext_bypass_d;
  reg        ext_pwrdn_d;
  reg [8:0]  mult_d;
  reg [4:0]  div_d;
  reg [2:0]  osc_src_d;
  reg        internal_oscillator_run_d;
  reg        main_oscillator_run_d;
  reg        pll_bypass_d;
  reg        pll_pwrdn_d;

  wire       accept;
  wire       wr_run;
  wire       wr_ext;
  wire [3:0] new_crystal_value_code;
  wire [31:0] run_rd;
  wire [31:0] ext_rd;
  wire [31:0] xlat_rd;

  assign accept   = hsel_in & htrans_in[1] & hready_in;
  assign wr_run   = wr_pend_q & ocpc_hit(addr_q, `OCPC_RUN_CFG_ADDR);
  assign wr_ext   = wr_pend_q & ocpc_hit(addr_q, `OCPC_EXT_CFG_ADDR);
  assign new_crystal_value_code = hwdata_in[`OCPC_CRYSTAL_VALUE_CODE_HI:`OCPC_CRYSTAL_VALUE_CODE_LO];

  assign run_rd = {18'h00000, pwrdn_q, 1'h1, bypass_q, 1'h0, crystal_value_code_q,
                   src_q, 2'h0, internal_oscillator_off_q, main_oscillator_off_q}; // RQ4
  assign ext_rd = {ext_use_q, 2'h0, 6'h00, 9'h000, ext_pwrdn_q, 1'h0,
                   ext_bypass_q, 4'h0, ext_src_q, 4'h0};
  assign xlat_rd = {18'h00000, mult_q, div_q}; // RQ9

  // ------------------------------------------------------------
  // Bus slave
  // ------------------------------------------------------------
  // Reads take one wait state so a write just before is seen
  always @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      hready_q  <= 1'h1;
      rd_pend_q <= 1'h0;
      wr_pend_q <= 1'h0;
      addr_q    <= 12'h000;
      hrdata_q  <= 32'h00000000;
      hresp_q   <= 1'h0;
    end else begin
      hresp_q   <= 1'h0;
      wr_pend_q <= accept & hwrite_in;
      rd_pend_q <= accept & ~hwrite_in;
      if (accept) begin
        addr_q <= {haddr_in[11:2], 2'h0};
      end
      if (accept & ~hwrite_in) begin
        hready_q <= 1'h0;
      end else begin
        hready_q <= 1'h1;
      end
      if (rd_pend_q) begin
        hrdata_q <= rd_word_d;
      end
    end
  end

  // Unmapped words read zero and ignore writes
  always @* begin
    case (addr_q)
      `OCPC_RUN_CFG_ADDR: rd_word_d = run_rd;
      `OCPC_XLAT_ADDR:    rd_word_d = xlat_rd; // RQ9
      `OCPC_EXT_CFG_ADDR: rd_word_d = ext_rd;
      default:            rd_word_d = 32'h00000000;
    endcase
  end

  // ------------------------------------------------------------
  // Configuration registers
  // ------------------------------------------------------------
  // Fields hold unless their own register is written
  always @* begin
    src_d        = src_q;
    crystal_value_code_d       = crystal_value_code_q;
    internal_oscillator_off_d   = internal_oscillator_off_q;
    main_oscillator_off_d   = main_oscillator_off_q;
    bypass_d     = bypass_q;
    pwrdn_d      = pwrdn_q;
    ext_use_d    = ext_use_q;
    ext_src_d    = ext_src_q;
    ext_bypass_d = ext_bypass_q;
    ext_pwrdn_d  = ext_pwrdn_q;
    if (wr_run) begin
      src_d      = hwdata_in[`OCPC_SRC_HI:`OCPC_SRC_LO]; // RQ1
      crystal_value_code_d     = new_crystal_value_code; // RQ10
      internal_oscillator_off_d = hwdata_in[`OCPC_INTERNAL_OSCILLATOR_OFF_BIT]; // RQ2
      main_oscillator_off_d = hwdata_in[`OCPC_MAIN_OSCILLATOR_OFF_BIT]; // RQ3
      bypass_d   = hwdata_in[`OCPC_BYPASS_BIT];
      pwrdn_d    = hwdata_in[`OCPC_PWRDN_BIT];
    end
    if (wr_ext) begin
      ext_use_d    = hwdata_in[`OCPC_EXT_USE_BIT];
      ext_src_d    = hwdata_in[`OCPC_EXT_SRC_HI:`OCPC_EXT_SRC_LO];
      ext_bypass_d = hwdata_in[`OCPC_BYPASS_BIT];
      ext_pwrdn_d  = hwdata_in[`OCPC_PWRDN_BIT];
    end
  end

  always @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      src_q        <= `OCPC_RST_SRC; // RQ1
      crystal_value_code_q       <= `OCPC_RST_CRYSTAL_VALUE_CODE; // RQ10
      internal_oscillator_off_q   <= `OCPC_RST_INTERNAL_OSCILLATOR_OFF; // RQ2
      main_oscillator_off_q   <= `OCPC_RST_MAIN_OSCILLATOR_OFF; // RQ3
      bypass_q     <= `OCPC_RST_BYPASS;
      pwrdn_q      <= `OCPC_RST_PWRDN;
      ext_use_q    <= `OCPC_RST_EXT_USE;
      ext_src_q    <= `OCPC_RST_EXT_SRC;
      ext_bypass_q <= `OCPC_RST_EXT_BYPASS;
      ext_pwrdn_q  <= `OCPC_RST_EXT_PWRDN;
    end else begin
      src_q        <= src_d;
      crystal_value_code_q       <= crystal_value_code_d;
      internal_oscillator_off_q   <= internal_oscillator_off_d;
      main_oscillator_off_q   <= main_oscillator_off_d;
      bypass_q     <= bypass_d;
      pwrdn_q      <= pwrdn_d;
      ext_use_q    <= ext_use_d;
      ext_src_q    <= ext_src_d;
      ext_bypass_q <= ext_bypass_d;
      ext_pwrdn_q  <= ext_pwrdn_d;
    end
  end

  // ------------------------------------------------------------
  // Translation register
  // ------------------------------------------------------------
  // Only a changed code reloads, so the PLL inputs never glitch
  always @* begin
    mult_d = mult_q;
    div_d  = div_q;
    if (wr_run && (new_crystal_value_code != crystal_value_code_q)) begin // RQ12
      mult_d = `OCPC_MULT_DEFAULT; // RQ5
      div_d  = ocpc_div_of(new_crystal_value_code); // RQ5
    end
  end

  always @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      mult_q <= `OCPC_MULT_DEFAULT; // RQ5
      div_q  <= `OCPC_RST_DIV; // RQ5
    end else begin
      mult_q <= mult_d;
      div_q  <= div_d;
    end
  end

  // ------------------------------------------------------------
  // Clock control outputs
  // ------------------------------------------------------------
  // Override resolved before the flop so the PLL sees one settled set
  always @* begin
    if (ext_use_q) begin
      osc_src_d    = ext_src_q; // RQ11
      pll_bypass_d = ext_bypass_q; // RQ11
      pll_pwrdn_d  = ext_pwrdn_q; // RQ11
    end else begin
      osc_src_d    = {1'h0, src_q}; // RQ1
      pll_bypass_d = bypass_q;
      pll_pwrdn_d  = pwrdn_q;
    end
    internal_oscillator_run_d = ~internal_oscillator_off_q; // RQ2
    main_oscillator_run_d = ~main_oscillator_off_q; // RQ3
  end

  always @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      osc_src_q    <= {1'h0, `OCPC_RST_SRC};
      internal_oscillator_run_q   <= 1'h1;
      main_oscillator_run_q   <= 1'h0;
      pll_bypass_q <= `OCPC_RST_BYPASS;
      pll_pwrdn_q  <= `OCPC_RST_PWRDN;
    end else begin
      osc_src_q    <= osc_src_d;
      internal_oscillator_run_q   <= internal_oscillator_run_d;
      main_oscillator_run_q   <= main_oscillator_run_d;
      pll_bypass_q <= pll_bypass_d;
      pll_pwrdn_q  <= pll_pwrdn_d;
    end
  end

  assign hreadyout_out        = hready_q;
  assign hresp_out            = hresp_q;
  assign hrdata_out           = hrdata_q;
  assign osc_source_out       = osc_src_q;
  assign internal_osc_run_out = internal_oscillator_run_q;
  assign main_osc_run_out     = main_oscillator_run_q;
  assign pll_bypass_out       = pll_bypass_q;
  assign pll_power_down_out   = pll_pwrdn_q;
  assign pll_mult_out         = mult_q; // RQ6 RQ7
  assign pll_div_out          = div_q; // RQ6 RQ8

endmodule // ocpc_top

// ---- logic/ocpc_map.vh ----
`ifndef OCPC_MAP_VH
`define OCPC_MAP_VH

// --------------------------------------------------------------
// Register byte offsets
// --------------------------------------------------------------
`define OCPC_RUN_CFG_ADDR    12'h060
`define OCPC_XLAT_ADDR       12'h064
`define OCPC_EXT_CFG_ADDR    12'h070

// --------------------------------------------------------------
// Run-mode clock configuration fields
// --------------------------------------------------------------
`define OCPC_MAIN_OSCILLATOR_OFF_BIT    0
`define OCPC_INTERNAL_OSCILLATOR_OFF_BIT    1
`define OCPC_SRC_HI          5
`define OCPC_SRC_LO          4
`define OCPC_CRYSTAL_VALUE_CODE_HI         9
`define OCPC_CRYSTAL_VALUE_CODE_LO         6
`define OCPC_BYPASS_BIT      11
`define OCPC_RSVD_ONE_BIT    12
`define OCPC_PWRDN_BIT       13

// --------------------------------------------------------------
// Extended clock configuration fields
// --------------------------------------------------------------
`define OCPC_EXT_SRC_HI      6
`define OCPC_EXT_SRC_LO      4
`define OCPC_EXT_USE_BIT     31

// --------------------------------------------------------------
// Translation fields
// --------------------------------------------------------------
`define OCPC_MULT_HI         13
`define OCPC_MULT_LO         5
`define OCPC_DIV_HI          4
`define OCPC_DIV_LO          0

// --------------------------------------------------------------
// Reset values
// --------------------------------------------------------------
`define OCPC_RST_SRC         2'h1
`define OCPC_RST_CRYSTAL_VALUE_CODE        4'hb
`define OCPC_RST_INTERNAL_OSCILLATOR_OFF    1'h0
`define OCPC_RST_MAIN_OSCILLATOR_OFF    1'h1
`define OCPC_RST_BYPASS      1'h1
`define OCPC_RST_PWRDN       1'h1
`define OCPC_RST_EXT_USE     1'h0
`define OCPC_RST_EXT_SRC     3'h1
`define OCPC_RST_EXT_BYPASS  1'h1
`define OCPC_RST_EXT_PWRDN   1'h1

// --------------------------------------------------------------
// Translation table defaults
// --------------------------------------------------------------
`define OCPC_MULT_DEFAULT    9'h190
`define OCPC_RST_DIV         5'h05

`endif

// ---- dv/ocpc_chk_asserts.sv ----
`timescale 1ns/100ps
module ocpc_chk (
  input wire        core_clk_in,
  input wire        reset_n_in,
  input wire        hsel_in,
  input wire [1:0]  htrans_in,
  input wire        hwrite_in,
  input wire        hready_in,
  input wire        hreadyout_out,
  input wire        hresp_out,
  input wire [31:0] hrdata_out,
  input wire [2:0]  osc_source_out,
  input wire        internal_osc_run_out,
  input wire        main_osc_run_out,
  input wire [8:0]  pll_mult_out,
  input wire [4:0]  pll_div_out
);
  // ------------
  // Bus and clock
  // ------------
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!reset_n_in);
  wire tk = hsel_in & htrans_in[1] & hready_in;
  wire wr = tk & hwrite_in;

  chk_resp_okay: assert property (hresp_out == 1'b0)
    else $error("Response not OKAY");
  chk_mult_fixed: assert property (pll_mult_out == 9'h190)
    else $error("Multiplier wrong");
  chk_rd_wait: assert property (tk && !hwrite_in |=>
    !hreadyout_out ##1 hreadyout_out)
    else $error("Read wait state wrong");
  chk_wr_nowait: assert property (wr |=> hreadyout_out)
    else $error("Write stalled");
  chk_rdata_hold: assert property ($changed(hrdata_out) |->
    $rose(hreadyout_out))
    else $error("Read data moved");
  chk_src_cause: assert property ($changed(osc_source_out) |->
    $past(wr, 3))
    else $error("Source changed without write");
  chk_osc_cause: assert property ($changed({internal_osc_run_out,
    main_osc_run_out}) |-> $past(wr, 3))
    else $error("Oscillator run changed without write");
  chk_div_cause: assert property ($changed(pll_div_out) |->
    $past(wr, 2))
    else $error("Divider changed without write");

  cover property (tk && !hwrite_in);
  cover property ($changed(pll_div_out));
  cover property ($changed(osc_source_out));
endmodule // ocpc_chk

bind ocpc_top ocpc_chk u_ocpc_chk (.core_clk_in, .reset_n_in,
  .hsel_in, .htrans_in, .hwrite_in, .hready_in, .hreadyout_out,
  .hresp_out, .hrdata_out, .osc_source_out, .internal_osc_run_out,
  .main_osc_run_out, .pll_mult_out, .pll_div_out);

// ---- dv/osc_source_and_pll_config_tb.sv ----
`timescale 1ns/100ps
module osc_source_and_pll_config_tb;
  reg         clk = 1'b0;
  reg         rst_n = 1'b0;
  reg         hsel = 1'b0;
  reg         hwrite = 1'b0;
  reg  [1:0]  htrans = 2'h0;
  reg  [31:0] haddr = 32'h0;
  reg  [31:0] hwdata = 32'h0;
  wire        rdy;
  wire        resp;
  wire [31:0] rdata;
  wire [2:0]  src;
  wire        irun;
  wire        mrun;
  wire        byp;
  wire        pdn;
  wire [8:0]  mult;
  wire [4:0]  div;
  integer     n_errors = 0;
  integer     checks_done = 0;
  integer     cyc = 0;
  integer     i;
  reg  [31:0] seed = 32'h0b57;
  reg  [31:0] v;
  reg  [31:0] r;

  always #2.5 clk = ~clk;

  ocpc_top u_ocpc_top (.core_clk_in(clk), .reset_n_in(rst_n),
    .hsel_in(hsel), .haddr_in(haddr), .htrans_in(htrans),
    .hwrite_in(hwrite), .hsize_in(3'h2), .hwdata_in(hwdata),
    .hready_in(rdy), .hreadyout_out(rdy), .hresp_out(resp),
    .hrdata_out(rdata), .osc_source_out(src),
    .internal_osc_run_out(irun), .main_osc_run_out(mrun),
    .pll_bypass_out(byp), .pll_power_down_out(pdn),
    .pll_mult_out(mult), .pll_div_out(div));

  // ------------
  // Helpers
  // ------------
  function [31:0] xs(input [31:0] x);
    begin
      x = x ^ (x << 13);
      x = x ^ (x >> 17);
      xs = x ^ (x << 5);
    end
  endfunction

  // Divider per crystal code, one nibble each
  function [4:0] ediv(input [3:0] c);
    reg [63:0] t;
    begin
      t = 64'h7765_5444_3333_1110;
      ediv = {1'b0, t[4*c +: 4]};
    end
  endfunction

  task cmp(input [8*10:1] nm, input [31:0] e, input [31:0] g);
    begin
      checks_done = checks_done + 1;
      if (g !== e) begin
        n_errors = n_errors + 1;
        $display("Error %0s expected %h seen %h", nm, e, g);
      end
    end
  endtask

  task xfer(input w, input [31:0] a, input [31:0] d, output [31:0] q);
    begin
      @(posedge clk);
      hsel <= 1'b1;
      haddr <= a;
      hwrite <= w;
      htrans <= 2'h2;
      do @(posedge clk); while (rdy !== 1'b1);
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge clk); while (rdy !== 1'b1);
      q = rdata;
    end
  endtask

  task end_sim;
    begin
      $display("Checks %0d errors %0d", checks_done, n_errors);
      if (n_errors == 0 && checks_done > 0)
        $display("Test passed");
      else
        $display("Test failed");
      $finish;
    end
  endtask

  // Generous: the whole sequence needs well under 2000 cycles
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      n_errors = n_errors + 1;
      end_sim;
    end
  end

  initial begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    xfer(1'b0, 32'h060, 32'h0, r);
    cmp("cfg rst", 32'h3ad1, r);
    xfer(1'b0, 32'h064, 32'h0, r);
    cmp("xlat rst", 32'h3205, r);
    cmp("mult", 32'h190, {23'h0, mult});
    cmp("runs", 32'h2, {30'h0, irun, mrun});
    for (i = 0; i < 24; i = i + 1) begin
      seed = xs(seed);
      v = {seed[31:6], i[1:0], seed[3:0]};
      xfer(1'b1, 32'h060, v, r);
      xfer(1'b1, 32'h064, seed, r);
      xfer(1'b0, 32'h064, 32'h0, r);
      cmp("xlat", {18'h0, 9'h190, ediv(v[9:6])}, r);
      xfer(1'b0, 32'h060, 32'h0, r);
      cmp("cfg", (v & 32'h2bf3) | 32'h1000, r);
      cmp("src", {30'h0, v[5:4]}, {29'h0, src});
      cmp("runs", {30'h0, ~v[1:0]}, {30'h0, irun, mrun});
      cmp("div", {27'h0, ediv(v[9:6])}, {27'h0, div});
      cmp("pll ctl", {30'h0, v[11], v[13]}, {30'h0, byp, pdn});
    end
    // Extended override, then an unmapped word to let it settle
    xfer(1'b1, 32'h070, 32'h8000_0040, r);
    xfer(1'b1, 32'h07c, seed, r);
    xfer(1'b0, 32'h07c, 32'h0, r);
    cmp("unmapped", 32'h0, r);
    cmp("ext src", 32'h4, {29'h0, src});
    cmp("ext pll", 32'h0, {30'h0, byp, pdn});
    end_sim;
  end
endmodule // osc_source_and_pll_config_tb
